// ---- hw/rst_src.sv ----
// Summary of operation
// R1: Software watchdog underflow raises its reset factor and starts a chip reset.
// R2: All four factors drop by themselves once the reset has been issued.
// R3: Software watchdog reset spares the hardware watchdog and its controls.
// R4: Software watchdog reset sets cause bit 4.
// R5: Hardware watchdog underflow raises its reset factor and starts a chip reset.
// R6: Hardware watchdog reset sets cause bit 5.
// R7: Main or sub oscillator stop raises the oscillator failure reset factor.
// R8: Oscillator failure reset sets cause bit 6.
// R9: Supervisor status shows sub failure at bit 1, main failure at bit 0.
// R10: Oscillator failure reset keeps the failure indication registers.
// R11: Main oscillator frequency outside window raises the frequency anomaly factor.
// R12: Frequency anomaly reset keeps part of the frequency detection registers.
// R13: Frequency anomaly reset sets cause bit 7.
// R14: These resets leave cause, LVD high byte, wake, RAM-retain, backup registers alone.
// R15: Everything else returns to default except debug, deep standby, some RTC.
// R16: Cause flags clear only on power-on reset and otherwise accumulate.
// R17: With reset enable, first anomaly interrupts only, second one resets.
// R18: Internal reset is held a fixed minimum count, then released synchronously.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "rst_src_params.svh"

module rst_src
  import rst_src_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic por_i,
  input wire logic soft_wdog_uflow_i,
  input wire logic hard_wdog_uflow_i,
  input wire logic main_osc_stop_i,
  input wire logic sub_osc_stop_i,
  input wire logic freq_out_of_window_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sys_rst_o,
  output logic bus_rst_o,
  output logic soft_scope_rst_o,
  output logic hard_wdog_rst_o,
  output logic osc_det_rst_o,
  output logic freq_det_rst_o,
  output logic irq_o
);

  // ==========================================================================
  // Input synchronisers.
  // ==========================================================================
  // Event lines arrive from other clock trees; two flops settle them before the edge detector.
  localparam int NSRC = 5;
  logic [NSRC-1:0] raw_in;
  logic [NSRC-1:0] sync1_ff;
  logic [NSRC-1:0] sync2_ff;
  logic [NSRC-1:0] prev_ff;
  logic [NSRC-1:0] rise;

  assign raw_in = {freq_out_of_window_i, sub_osc_stop_i, main_osc_stop_i,
                   hard_wdog_uflow_i, soft_wdog_uflow_i};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Only a rising edge counts, so a source that stays high cannot fire twice.
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_edge
      assign rise[g] = sync2_ff[g] & ~prev_ff[g];
    end
  endgenerate

  // ==========================================================================
  // Reset factors.
  // ==========================================================================
  logic ctrl_freq_rst_en_ff;
  logic freq_seen_ff;
  logic soft_ev;
  logic hard_ev;
  logic osc_ev;
  logic freq_ev;
  logic freq_warn_ev;
  logic seq_busy;

  // Events that arrive while a reset is held are dropped on purpose.
  assign soft_ev = rise[0] & ~seq_busy; // R1
  assign hard_ev = rise[1] & ~seq_busy; // R5
  assign osc_ev = (rise[2] | rise[3]) & ~seq_busy; // R7
  assign freq_ev = rise[4] & ~seq_busy & ctrl_freq_rst_en_ff & freq_seen_ff; // R11 R17
  assign freq_warn_ev = rise[4] & ~seq_busy & ~(ctrl_freq_rst_en_ff & freq_seen_ff); // R17

  // Without the reset enable every anomaly only warns; with it the first warns, the second resets.
  // First anomaly is remembered until the second one starts the frequency anomaly reset; srst_i or por_i also clears it.
  always_ff @(posedge clk_i) begin
    if (srst_i || por_i) begin
      freq_seen_ff <= 1'b0;
    end else if (freq_ev) begin
      freq_seen_ff <= 1'b0;
    end else if (freq_warn_ev && ctrl_freq_rst_en_ff) begin
      freq_seen_ff <= 1'b1; // R17
    end
  end

  // ==========================================================================
  // Reset hold sequencer.
  // ==========================================================================
  // The counter runs from zero to the last hold cycle, so the reset stands the full count.
  localparam logic [5:0] HOLD_LAST = 6'(`HOLD_CYC - 1);
  seq_state_e state_ff;
  logic [5:0] hold_cnt_ff;
  logic [3:0] kind_ff;
  logic any_ev;

  assign any_ev = soft_ev | hard_ev | osc_ev | freq_ev;
  assign seq_busy = (state_ff == ST_HOLD);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff <= ST_IDLE;
      hold_cnt_ff <= '0;
      kind_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (any_ev) begin
            state_ff <= ST_HOLD;
            hold_cnt_ff <= '0;
            kind_ff <= {freq_ev, osc_ev, hard_ev, soft_ev};
          end
        end
        ST_HOLD: begin
          if (hold_cnt_ff == HOLD_LAST) begin
            state_ff <= ST_IDLE; // R2 R18
            kind_ff <= '0;
          end else begin
            hold_cnt_ff <= hold_cnt_ff + 6'h01; // R18
          end
        end
      endcase
    end
  end

  logic hold_next;
  logic [3:0] kind_next;

  // Next reset level and factor kind, so the outputs rise in the same cycle as the state.
  always_comb begin
    hold_next = 1'b0;
    kind_next = 4'h0;
    if (state_ff == ST_IDLE) begin
      hold_next = any_ev;
      kind_next = {freq_ev, osc_ev, hard_ev, soft_ev};
    end else if (hold_cnt_ff != HOLD_LAST) begin
      hold_next = 1'b1;
      kind_next = kind_ff;
    end
  end

  // Each scoped output stays low for the factor whose block it must spare.

  // Reset outputs: hard watchdog and detector retention blocks see only scoped resets.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sys_rst_o <= 1'b0;
      bus_rst_o <= 1'b0;
      soft_scope_rst_o <= 1'b0;
      hard_wdog_rst_o <= 1'b0;
      osc_det_rst_o <= 1'b0;
      freq_det_rst_o <= 1'b0;
    end else begin
      sys_rst_o <= hold_next; // R15
      bus_rst_o <= hold_next; // R15
      soft_scope_rst_o <= hold_next;
      hard_wdog_rst_o <= hold_next & ~kind_next[0]; // R3
      osc_det_rst_o <= hold_next & ~kind_next[2]; // R10
      freq_det_rst_o <= hold_next & ~kind_next[3]; // R12
    end
  end

  // ==========================================================================
  // Cause and supervisor status registers (retained, power-on cleared).
  // ==========================================================================
  logic [7:0] cause_ff;
  logic [1:0] supv_ff;

  // Cause flags ignore the chip reset; only power-on clears them, so factors accumulate.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      cause_ff <= `CAUSE_RST; // R16
    end else begin
      if (soft_ev) begin
        cause_ff[`BIT_SOFT_WDOG] <= 1'b1; // R4 R14
      end
      if (hard_ev) begin
        cause_ff[`BIT_HARD_WDOG] <= 1'b1; // R6
      end
      if (osc_ev) begin
        cause_ff[`BIT_OSC_FAIL] <= 1'b1; // R8
      end
      if (freq_ev) begin
        cause_ff[`BIT_FREQ] <= 1'b1; // R13
      end
    end
  end

  // The supervisor status keeps each failing oscillator until power-on.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      supv_ff <= 2'h0;
    end else if (osc_ev) begin
      supv_ff[`BIT_SUB_OSC] <= supv_ff[`BIT_SUB_OSC] | rise[3]; // R9 R10
      supv_ff[`BIT_MAIN_OSC] <= supv_ff[`BIT_MAIN_OSC] | rise[2]; // R9
    end
  end

  // ==========================================================================
  // Interrupt status.
  // ==========================================================================
  logic [4:0] irq_stat_ff;
  logic [4:0] irq_en_ff;
  logic [4:0] irq_set;
  logic [4:0] irq_clr;
  assign irq_set = {freq_warn_ev, freq_ev, osc_ev, hard_ev, soft_ev};

  // A new event wins over a clear in the same cycle.

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  // The output follows the next status value so it has no extra cycle of delay.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
    end
  end

  // ==========================================================================
  // AXI4-Lite slave.
  // ==========================================================================
  logic aw_ok_ff;
  logic w_ok_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_go;
  logic wr_ctrl;
  logic wr_irq_en;
  logic wr_irq_clr;

  // Address and data are taken in either order; the response waits for both.
  // Each ready pulses for one cycle and stays low until the write completes.
  assign wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign wr_ctrl = wr_go && w_strb_ff[0] && (aw_addr_ff == `OFS_CTRL);
  assign wr_irq_en = wr_go && w_strb_ff[0] && (aw_addr_ff == `OFS_IRQ_EN);
  assign wr_irq_clr = wr_go && w_strb_ff[0] && (aw_addr_ff == `OFS_IRQ_CLR);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr_ff) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `OFS_CAUSE) || (a == `OFS_SUPV) || (a == `OFS_CTRL) ||
              (a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_EN) || (a == `OFS_IRQ_CLR);
  endfunction : addr_ok

  assign irq_clr = wr_irq_clr ? w_data_ff[4:0] : 5'h0;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_en_ff <= '0;
      ctrl_freq_rst_en_ff <= `CTRL_RST;
    end else begin
      if (wr_irq_en) begin
        irq_en_ff <= w_data_ff[4:0];
      end
      if (wr_ctrl) begin
        ctrl_freq_rst_en_ff <= w_data_ff[`BIT_FREQ_RST_EN]; // R17
      end
    end
  end

  // Unmapped addresses answer with an error response and zero data.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr[7:0])
      `OFS_CAUSE: rd_mux = {24'h0, cause_ff};
      `OFS_SUPV: rd_mux = {30'h0, supv_ff};
      `OFS_CTRL: rd_mux = {31'h0, ctrl_freq_rst_en_ff};
      `OFS_IRQ_STAT: rd_mux = {27'h0, irq_stat_ff};
      `OFS_IRQ_EN: rd_mux = {27'h0, irq_en_ff};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_ok(s_axi_araddr[7:0]) ? 2'h0 : 2'h2;
        s_axi_rdata <= rd_mux;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : rst_src

// ---- hw/rst_src_params.svh ----
`ifndef RST_SRC_PARAMS_SVH
`define RST_SRC_PARAMS_SVH

// Register byte offsets.
`define OFS_CAUSE 8'h00
`define OFS_SUPV 8'h04
`define OFS_CTRL 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_EN 8'h10
`define OFS_IRQ_CLR 8'h14

// Field positions in the cause register.
`define BIT_PWRON 0
`define BIT_SOFT_WDOG 4
`define BIT_HARD_WDOG 5
`define BIT_OSC_FAIL 6
`define BIT_FREQ 7

// Field positions in the supervisor status register.
`define BIT_MAIN_OSC 0
`define BIT_SUB_OSC 1

// Control register field positions.
`define BIT_FREQ_RST_EN 0

// Interrupt status bit positions.
`define IRQ_SOFT 0
`define IRQ_HARD 1
`define IRQ_OSC 2
`define IRQ_FREQ 3
`define IRQ_FREQ_FIRST 4

// Reset values.
`define CAUSE_RST 8'h01
`define CTRL_RST 1'b0

// Minimum internal reset hold time in ns and its cycle count.
`define HOLD_NS 320
`define CLK_NS 10
`define HOLD_CYC ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- hw/rst_src_pkg.sv ----
package rst_src_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } seq_state_e;
endpackage : rst_src_pkg

// ---- testbench/rst_ev_model.sv ----
`timescale 1ns/100ps
// ========
// Watchdog and supervisor side: each request raises its event line for three cycles.
module rst_ev_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [4:0] go_i,
  output logic [4:0] ev_o
);
  logic [4:0] a_ff, b_ff, c_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      a_ff <= 5'h00;
      b_ff <= 5'h00;
      c_ff <= 5'h00;
    end else begin
      a_ff <= go_i;
      b_ff <= a_ff;
      c_ff <= b_ff;
    end
  end
  assign ev_o = a_ff | b_ff | c_ff;
endmodule : rst_ev_model

// ---- testbench/rst_src_chk.sv ----
`timescale 1ns/100ps
// ========
// Reset sequence checks.
module rst_src_chk (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic soft_wdog_uflow_i,
  input wire logic hard_wdog_uflow_i,
  input wire logic main_osc_stop_i,
  input wire logic sub_osc_stop_i,
  input wire logic sys_rst_o,
  input wire logic bus_rst_o,
  input wire logic soft_scope_rst_o,
  input wire logic hard_wdog_rst_o,
  input wire logic osc_det_rst_o,
  input wire logic freq_det_rst_o
);
  logic [7:0] cnt_ff;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  always_ff @(posedge clk_i) begin
    if (srst_i || !sys_rst_o)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
  AST_HOLD_LEN: assert property ($fell(sys_rst_o) |-> cnt_ff == 8'h20)
    else $error("hold length");
  AST_HOLD_MAX: assert property (cnt_ff <= 8'h20)
    else $error("hold too long");
  AST_SCOPE: assert property (bus_rst_o == sys_rst_o && soft_scope_rst_o == sys_rst_o)
    else $error("bus reset differs");
  AST_SUBSET: assert property ((hard_wdog_rst_o || osc_det_rst_o || freq_det_rst_o) |-> sys_rst_o)
    else $error("partial reset alone");
  AST_SOFT: assert property ($rose(soft_wdog_uflow_i) && !sys_rst_o |-> ##[2:8] (sys_rst_o && !hard_wdog_rst_o))
    else $error("soft reset");
  AST_HARD: assert property ($rose(hard_wdog_uflow_i) && !sys_rst_o |-> ##[2:8] (hard_wdog_rst_o && osc_det_rst_o))
    else $error("hard reset");
  AST_MAIN: assert property ($rose(main_osc_stop_i) && !sys_rst_o |-> ##[2:8] (sys_rst_o && !osc_det_rst_o))
    else $error("main osc reset");
  AST_SUB: assert property ($rose(sub_osc_stop_i) && !sys_rst_o |-> ##[2:8] (sys_rst_o && !osc_det_rst_o))
    else $error("sub osc reset");
endmodule : rst_src_chk

bind rst_src rst_src_chk u_rst_src_chk (.clk_i(clk_i), .srst_i(srst_i),
  .soft_wdog_uflow_i(soft_wdog_uflow_i), .hard_wdog_uflow_i(hard_wdog_uflow_i),
  .main_osc_stop_i(main_osc_stop_i), .sub_osc_stop_i(sub_osc_stop_i),
  .sys_rst_o(sys_rst_o), .bus_rst_o(bus_rst_o), .soft_scope_rst_o(soft_scope_rst_o),
  .hard_wdog_rst_o(hard_wdog_rst_o), .osc_det_rst_o(osc_det_rst_o),
  .freq_det_rst_o(freq_det_rst_o));

// ---- testbench/rst_src_tb.sv ----
`timescale 1ns/100ps
module rst_src_tb;
  logic clk_i = 1'b0, srst_i = 1'b1, por_i = 1'b1;
  logic [4:0] go = 5'h00, ev;
  logic soft_wdog_uflow_i, hard_wdog_uflow_i, main_osc_stop_i, sub_osc_stop_i;
  logic freq_out_of_window_i, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, sys_rst_o, bus_rst_o, soft_scope_rst_o;
  logic hard_wdog_rst_o, osc_det_rst_o, freq_det_rst_o, irq_o;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0, n_checks = 0;
  assign {freq_out_of_window_i, sub_osc_stop_i, main_osc_stop_i} = ev[4:2];
  assign {hard_wdog_uflow_i, soft_wdog_uflow_i} = ev[1:0];
  rst_src u_rst_src (.*);
  rst_ev_model u_rst_ev_model (.clk_i(clk_i), .srst_i(srst_i), .go_i(go), .ev_o(ev));
  always #5 clk_i = ~clk_i;
  // ========
  // Shared bus and compare tasks.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd
  task automatic ev_run(input int k, input logic hit, input logic [2:0] keep);
    int n;
    n = 0;
    go[k] <= 1'b1;
    @(posedge clk_i);
    go[k] <= 1'b0;
    while (!sys_rst_o && n < 12) begin
      @(posedge clk_i);
      n++;
    end
    chk("reset seen", {31'h0, hit}, {31'h0, sys_rst_o});
    n = 0;
    while (sys_rst_o && n < 40) begin
      chk("kept", {29'h0, keep}, {29'h0, hard_wdog_rst_o, osc_det_rst_o, freq_det_rst_o});
      @(posedge clk_i);
      n++;
    end
    if (hit)
      chk("hold", 32'h20, n);
  endtask : ev_run
  // ========
  // Scenarios.
  task automatic t_regs;
    rd(32'h0, 32'h1, 2'h0);
    rd(32'h4, 32'h0, 2'h0);
    rd(32'h20, 32'h0, 2'h2);
    wr(32'h20, 32'h1, 2'h2);
  endtask : t_regs
  task automatic t_wdog;
    wr(32'h10, 32'h1, 2'h0);
    ev_run(0, 1'b1, 3'h3);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd(32'h0, 32'h11, 2'h0);
    wr(32'h14, 32'h1, 2'h0);
    rd(32'hC, 32'h0, 2'h0);
    chk("irq", 32'h0, {31'h0, irq_o});
    ev_run(1, 1'b1, 3'h7);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rd(32'h0, 32'h31, 2'h0);
    rd(32'hC, 32'h2, 2'h0);
  endtask : t_wdog
  task automatic t_osc;
    ev_run(2, 1'b1, 3'h5);
    rd(32'h0, 32'h71, 2'h0);
    rd(32'h4, 32'h1, 2'h0);
    ev_run(3, 1'b1, 3'h5);
    rd(32'h4, 32'h3, 2'h0);
  endtask : t_osc
  task automatic t_freq;
    ev_run(4, 1'b0, 3'h0);
    wr(32'h8, 32'h1, 2'h0);
    ev_run(4, 1'b0, 3'h0);
    ev_run(4, 1'b1, 3'h6);
    rd(32'h0, 32'hF1, 2'h0);
    rd(32'hC, 32'h1E, 2'h0);
  endtask : t_freq
  task automatic t_keep;
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(32'h0, 32'hF1, 2'h0);
    rd(32'h4, 32'h3, 2'h0);
    srst_i <= 1'b1;
    por_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    por_i <= 1'b0;
    rd(32'h0, 32'h1, 2'h0);
  endtask : t_keep
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    por_i <= 1'b0;
    t_regs();
    t_wdog();
    t_osc();
    t_freq();
    t_keep();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
endmodule : rst_src_tb
